// File: core/sysref_cal_engine.sv
/*
  SYSREF timing calibration engine. Each measurement captures the phase
  counter after a set number of SYSREF edges; the average of the
  measurements becomes the delay word.
  Assumes averaging and duration stay fixed while a sequence runs.
*/
module sysref_cal_engine (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sysref_rise_i,
  sysref_cal_if.engine cal
);
  typedef enum logic [1:0] {IDLE, MEASURE, FINISHED} cal_state_e;

  function automatic logic [8:0] span(input logic [1:0] code);
    span = sysref_cal_pkg::SPAN_BASE << {code, 1'b0};
  endfunction : span

  cal_state_e state_r;
  logic [16:0] phase_r;
  logic [8:0] edge_cnt_r;
  logic [8:0] sample_cnt_r;
  logic [24:0] acc_r;
  logic [16:0] result_r;
  wire [8:0] edges_need = span(cal.hdur);
  wire [8:0] samples_need = span(cal.avg);
  wire [8:0] edge_next = edge_cnt_r + 9'h001;
  wire [8:0] sample_next = sample_cnt_r + 9'h001;
  wire [24:0] acc_sum = acc_r + {8'h00, phase_r};
  wire [4:0] shift = sysref_cal_pkg::SHIFT_BASE + {2'b00, cal.avg, 1'b0};
  wire [24:0] acc_avg = acc_sum >> shift;
  wire take = (state_r == MEASURE) && sysref_rise_i && (edge_next == edges_need);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= 17'h00000;
    end else begin
      phase_r <= phase_r + 17'h00001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= IDLE;
      edge_cnt_r <= 9'h000;
      sample_cnt_r <= 9'h000;
      acc_r <= 25'h0000000;
      result_r <= 17'h00000;
    end else if (cal.abort) begin
      state_r <= IDLE;
    end else begin
      case (state_r)
        IDLE, FINISHED: begin
          if (cal.start) begin
            state_r <= MEASURE;
            edge_cnt_r <= 9'h000;
            sample_cnt_r <= 9'h000;
            acc_r <= 25'h0000000;
          end
        end
        MEASURE: begin
          if (sysref_rise_i) begin
            edge_cnt_r <= take ? 9'h000 : edge_next;
          end
          if (take) begin
            acc_r <= acc_sum;
            sample_cnt_r <= sample_next;
            if (sample_next == samples_need) begin // [RULE8]
              result_r <= acc_avg[16:0];
              state_r <= FINISHED;
            end
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  assign cal.busy = (state_r == MEASURE);
  assign cal.done = (state_r == FINISHED);
  assign cal.result = result_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_avg_count;
    $rose(cal.done) |-> (sample_cnt_r == samples_need) && (sample_cnt_r != 9'h000);
  endproperty
  a_avg_count: assert property (p_avg_count) else $error("wrong sample count"); // [RULE8]
endmodule : sysref_cal_engine

// File: core/sysref_cal_if.sv
/*
  Control and result signals between the register front end and the
  calibration engine. Both ends share one clock.
*/
interface sysref_cal_if;
  logic start;
  logic abort;
  logic [1:0] avg;
  logic [1:0] hdur;
  logic busy;
  logic done;
  logic [16:0] result;
  modport ctrl (output start, output abort, output avg, output hdur,
    input busy, input done, input result);
  modport engine (input start, input abort, input avg, input hdur,
    output busy, output done, output result);
endinterface : sysref_cal_if

// File: core/sysref_cal_pkg.sv
/*
  Constants for the SYSREF aperture delay calibration block: register
  indices, reset values and field positions.
  Assumes a 10 MHz device clock and APB word access at four times the index.
*/
// How it works
// RULE1: Enable low applies manual 17-bit delay word
// RULE2: Enable high takes delay from calibration
// RULE3: Manual delay ignored while calibration enabled
// RULE4: Enable rising edge starts one calibration
// RULE5: Software writes config before setting enable
// RULE6: Software checks converter calibration idle first
// RULE7: Group 0x2B0-0x2BF decoded, 0x2B9-0x2BF reserved
// RULE8: Average 4, 16, 64 or 256 measurements
// RULE9: Done flag reads one only while enabled
// RULE10: Held enable never restarts; clear then set
package sysref_cal_pkg;
  localparam logic [9:0] IDX_CAL_ENABLE = 10'h2b0;
  localparam logic [9:0] IDX_CAL_CONFIG = 10'h2b1;
  localparam logic [9:0] IDX_CAL_RESULT = 10'h2b2;
  localparam logic [9:0] IDX_DELAY_MANUAL = 10'h2b5;
  localparam logic [9:0] IDX_RAMP_CONTROL = 10'h2b8;
  localparam logic [9:0] IDX_RESERVED_FIRST = 10'h2b9;
  localparam logic [9:0] IDX_GROUP_FIRST = 10'h2b0;
  localparam logic [9:0] IDX_GROUP_LAST = 10'h2bf;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h2c0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h2c1;

  localparam logic [7:0] CAL_ENABLE_RST = 8'h00;
  localparam logic [7:0] CAL_CONFIG_RST = 8'h05;
  localparam logic [23:0] DELAY_MANUAL_RST = 24'h000000;
  localparam logic [7:0] RAMP_CONTROL_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  localparam int ENABLE_BIT = 0;
  localparam int AVG_LSB = 2;
  localparam int HDUR_LSB = 0;
  localparam int DONE_BIT = 17;
  localparam int DELAY_W = 17;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_START_BIT = 1;
  localparam int ACC_W = 25;
  localparam int SPAN_W = 9;
  localparam logic [8:0] SPAN_BASE = 9'h004;
  localparam logic [4:0] SHIFT_BASE = 5'h02;
endpackage : sysref_cal_pkg

// File: core/sysref_cal_top.sv
/*
  SYSREF aperture delay calibration block with its APB register slave.
  Assumes an APB master on CLOCK_I and a SYSREF pin from another domain.
*/
module sysref_cal_top (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SYSREF_I,
  output logic [16:0] SAMPLE_DELAY_O,
  output logic CAL_BUSY_O,
  output logic IRQ_O
);
  sysref_cal_if cal ();

  logic [7:0] enable_r;
  logic [7:0] config_r;
  logic [23:0] manual_r;
  logic [7:0] ramp_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic enable_prev_r;
  logic done_prev_r;
  logic [16:0] delay_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [31:0] rd_word;
  logic sysref_rise;

  sysref_edge_sync u_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .pin_i(SYSREF_I),
    .rise_o(sysref_rise)
  );

  sysref_cal_engine u_engine (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .sysref_rise_i(sysref_rise),
    .cal(cal.ctrl)
  );

  // Address decode
  wire [9:0] idx = PADDR_I[11:2];
  wire aligned = (PADDR_I[1:0] == 2'b00);
  wire in_group = (idx >= sysref_cal_pkg::IDX_GROUP_FIRST)
    && (idx <= sysref_cal_pkg::IDX_GROUP_LAST); // [RULE7]
  wire in_irq = (idx == sysref_cal_pkg::IDX_IRQ_STATUS)
    || (idx == sysref_cal_pkg::IDX_IRQ_MASK);
  wire addr_err = !aligned || !(in_group || in_irq);
  wire setup = PSEL_I && !PENABLE_I;
  wire wr = PSEL_I && PENABLE_I && PWRITE_I && !addr_err;
  wire wr_enable = wr && (idx == sysref_cal_pkg::IDX_CAL_ENABLE);
  wire wr_config = wr && (idx == sysref_cal_pkg::IDX_CAL_CONFIG);
  wire wr_manual = wr && (idx == sysref_cal_pkg::IDX_DELAY_MANUAL);
  wire wr_ramp = wr && (idx == sysref_cal_pkg::IDX_RAMP_CONTROL);
  wire wr_irq_status = wr && (idx == sysref_cal_pkg::IDX_IRQ_STATUS);
  wire wr_irq_mask = wr && (idx == sysref_cal_pkg::IDX_IRQ_MASK);

  // Calibration control
  wire enable_bit = enable_r[sysref_cal_pkg::ENABLE_BIT];
  wire cal_start = enable_bit && !enable_prev_r; // [RULE4] [RULE10]
  wire done_flag = enable_bit && cal.done; // [RULE9]
  wire done_event = cal.done && !done_prev_r;
  wire [1:0] irq_set = {cal_start, done_event};
  wire [1:0] irq_clr = wr_irq_status ? PWDATA_I[1:0] : 2'b00;
  wire [16:0] delay_nxt = enable_bit ? cal.result : manual_r[16:0]; // [RULE1] [RULE2] [RULE3]

  assign cal.start = cal_start;
  assign cal.abort = !enable_bit;
  assign cal.avg = config_r[sysref_cal_pkg::AVG_LSB +: 2]; // [RULE8]
  assign cal.hdur = config_r[sysref_cal_pkg::HDUR_LSB +: 2];

  // Read mux; reserved locations and upper bytes of wide registers read zero
  always_comb begin
    rd_word = 32'h00000000;
    case (idx)
      sysref_cal_pkg::IDX_CAL_ENABLE: rd_word = {24'h000000, enable_r};
      sysref_cal_pkg::IDX_CAL_CONFIG: rd_word = {24'h000000, config_r};
      sysref_cal_pkg::IDX_CAL_RESULT: rd_word = {14'h0000, done_flag, cal.result};
      sysref_cal_pkg::IDX_DELAY_MANUAL: rd_word = {8'h00, manual_r};
      sysref_cal_pkg::IDX_RAMP_CONTROL: rd_word = {24'h000000, ramp_r};
      sysref_cal_pkg::IDX_IRQ_STATUS: rd_word = {30'h00000000, irq_status_r};
      sysref_cal_pkg::IDX_IRQ_MASK: rd_word = {30'h00000000, irq_mask_r};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      enable_r <= sysref_cal_pkg::CAL_ENABLE_RST;
      config_r <= sysref_cal_pkg::CAL_CONFIG_RST;
      manual_r <= sysref_cal_pkg::DELAY_MANUAL_RST;
      ramp_r <= sysref_cal_pkg::RAMP_CONTROL_RST;
      irq_mask_r <= sysref_cal_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_enable) enable_r <= PWDATA_I[7:0];
      if (wr_config) config_r <= PWDATA_I[7:0];
      if (wr_manual) manual_r <= PWDATA_I[23:0];
      if (wr_ramp) ramp_r <= PWDATA_I[7:0];
      if (wr_irq_mask) irq_mask_r <= PWDATA_I[1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_status_r <= 2'b00;
      enable_prev_r <= 1'b0;
      done_prev_r <= 1'b0;
      delay_r <= 17'h00000;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      enable_prev_r <= enable_bit;
      done_prev_r <= cal.done;
      delay_r <= delay_nxt;
    end
  end

  // Read data captured in the setup phase so the access phase needs no wait
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= (PWRITE_I || addr_err) ? 32'h00000000 : rd_word;
      pslverr_r <= addr_err;
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = pslverr_r;
  assign SAMPLE_DELAY_O = delay_r;
  assign CAL_BUSY_O = cal.busy;
  assign IRQ_O = |(irq_status_r & irq_mask_r);

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  property p_manual_delay;
    !enable_bit |=> (SAMPLE_DELAY_O == $past(manual_r[16:0]));
  endproperty
  a_manual_delay: assert property (p_manual_delay) else $error("manual delay not applied"); // [RULE1]

  property p_auto_delay;
    enable_bit |=> (SAMPLE_DELAY_O == $past(cal.result));
  endproperty
  a_auto_delay: assert property (p_auto_delay) else $error("calibrated delay not applied"); // [RULE2]

  property p_manual_ignored;
    (enable_bit && $past(enable_bit) && wr_manual && $stable(cal.result)) |=>
      $stable(SAMPLE_DELAY_O);
  endproperty
  a_manual_ignored: assert property (p_manual_ignored) else $error("manual write moved delay"); // [RULE3]

  sequence s_enable_rise;
    !enable_bit ##1 enable_bit;
  endsequence
  property p_start_on_rise;
    s_enable_rise |=> cal.busy;
  endproperty
  a_start_on_rise: assert property (p_start_on_rise) else $error("calibration not started"); // [RULE4]

  property p_reserved_read;
    (setup && !PWRITE_I && (idx >= sysref_cal_pkg::IDX_RESERVED_FIRST) &&
      (idx <= sysref_cal_pkg::IDX_GROUP_LAST) && aligned) |=>
      (PRDATA_O == 32'h00000000) && !PSLVERR_O;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved read wrong"); // [RULE7]

  property p_done_needs_enable;
    !enable_bit |-> !done_flag ##1 (!cal.done && !cal.busy);
  endproperty
  a_done_needs_enable: assert property (p_done_needs_enable) else $error("done while disabled"); // [RULE9]

  property p_no_restart;
    (enable_bit && $past(enable_bit)) [*2] |-> !cal.start;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart while held"); // [RULE10]
endmodule : sysref_cal_top

// File: core/sysref_edge_sync.sv
/*
  Two-flop synchroniser for the SYSREF pin with a rising edge pulse.
  Assumes SYSREF pulses last at least two device clock cycles.
*/
module sysref_edge_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Only sync_r reads meta_r
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise_o = sync_r & ~prev_r;
endmodule : sysref_edge_sync

// File: test/sysref_aperture_delay_calibration_test.sv
/*
  Self-checking bench for the SYSREF calibration block: APB tasks and call
  sequences. Assumes the SYSREF source model of sysref_source.sv.
*/
module sysref_aperture_delay_calibration_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, cal;
  logic pready, pslverr, sysref, busy, irq, err, idle;
  logic go = 1'b0;
  logic [16:0] delay;
  logic [11:0] npulse = 12'h000;
  logic [3:0] cfg_tab [6] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h1, 4'h2};
  logic [9:0] rsv [3] = '{10'h2b3, 10'h2b9, 10'h2bf};
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;

  always #50 clk = ~clk;

  sysref_cal_top sysref_cal_top_inst (.CLOCK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SYSREF_I(sysref),
    .SAMPLE_DELAY_O(delay), .CAL_BUSY_O(busy), .IRQ_O(irq));
  sysref_source sysref_source_inst (.clk_i(clk), .rst_n_i(rst_n), .count_i(npulse),
    .go_i(go), .sysref_o(sysref), .idle_o(idle));

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Covers the longest averaging run with margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", name, e, g);
      errors++;
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d, rd, err);
    chk("write_error", 32'h0, err);
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0, rd, err);
    chk("read_data", e, rd);
    chk("read_error", 32'h0, err);
  endtask : rdc

  task automatic send(input int k);
    go <= 1'b1;
    npulse <= k[11:0];
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (idle !== 1'b1);
  endtask : send

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(sysref_cal_pkg::IDX_CAL_ENABLE, 32'h0);
    rdc(sysref_cal_pkg::IDX_CAL_CONFIG, 32'h5);
    rdc(sysref_cal_pkg::IDX_DELAY_MANUAL, 32'h0);
    rdc(sysref_cal_pkg::IDX_CAL_RESULT, 32'h0);
    rdc(sysref_cal_pkg::IDX_IRQ_MASK, 32'h0);
    chk("sample_delay", 32'h0, delay);
    wr(sysref_cal_pkg::IDX_DELAY_MANUAL, 32'h00f1abcd);
    rdc(sysref_cal_pkg::IDX_DELAY_MANUAL, 32'h00f1abcd);
    wr(sysref_cal_pkg::IDX_RAMP_CONTROL, 32'ha5);
    rdc(sysref_cal_pkg::IDX_RAMP_CONTROL, 32'ha5);
    repeat (2) @(posedge clk);
    chk("manual_delay", 32'h1abcd, delay);
    for (int i = 0; i < 3; i++) begin
      wr(rsv[i], 32'hff);
      rdc(rsv[i], 32'h0);
    end
    xfer(1'b1, 10'h2c2, 32'h1, rd, err);
    chk("unmapped_error", 32'h1, err);
    wr(sysref_cal_pkg::IDX_IRQ_MASK, 32'h3);
    // Every averaging code, then two longer measurement lengths
    for (int i = 0; i < 6; i++) begin
      n = (4 << (2 * cfg_tab[i][3:2])) * (4 << (2 * cfg_tab[i][1:0]));
      wr(sysref_cal_pkg::IDX_CAL_CONFIG, {28'h0, cfg_tab[i]});
      wr(sysref_cal_pkg::IDX_CAL_ENABLE, 32'h0);
      wr(sysref_cal_pkg::IDX_CAL_ENABLE, 32'h1); // no converter calibration here
      repeat (3) @(posedge clk);
      chk("busy_start", 32'h1, busy);
      send(n - 1);
      repeat (6) @(posedge clk);
      chk("busy_short", 32'h1, busy);
      send(1);
      repeat (8) @(posedge clk);
      chk("busy_end", 32'h0, busy);
      xfer(1'b0, sysref_cal_pkg::IDX_CAL_RESULT, 32'h0, cal, err);
      chk("done", 32'h1, cal[17]);
      chk("cal_delay", cal[16:0], delay);
      chk("irq_done", 32'h1, irq);
      rdc(sysref_cal_pkg::IDX_IRQ_STATUS, 32'h3);
      wr(sysref_cal_pkg::IDX_IRQ_STATUS, 32'h3);
      @(posedge clk);
      chk("irq_clear", 32'h0, irq);
    end
    wr(sysref_cal_pkg::IDX_DELAY_MANUAL, 32'h123);
    wr(sysref_cal_pkg::IDX_CAL_ENABLE, 32'h1);
    repeat (3) @(posedge clk);
    chk("held_delay", cal[16:0], delay);
    chk("no_restart", 32'h0, busy);
    wr(sysref_cal_pkg::IDX_IRQ_MASK, 32'h0);
    wr(sysref_cal_pkg::IDX_CAL_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    chk("manual_again", 32'h123, delay);
    xfer(1'b0, sysref_cal_pkg::IDX_CAL_RESULT, 32'h0, rd, err);
    chk("done_off", 32'h0, rd[17]);
    wr(sysref_cal_pkg::IDX_IRQ_STATUS, 32'h3);
    wr(sysref_cal_pkg::IDX_CAL_ENABLE, 32'h1);
    repeat (3) @(posedge clk);
    chk("restart", 32'h1, busy);
    chk("irq_masked", 32'h0, irq);
    rdc(sysref_cal_pkg::IDX_IRQ_STATUS, 32'h2);
    wr(sysref_cal_pkg::IDX_IRQ_MASK, 32'h2);
    @(posedge clk);
    chk("irq_unmasked", 32'h1, irq);
    conclude();
  end
endmodule : sysref_aperture_delay_calibration_test

// File: test/sysref_source.sv
/*
  SYSREF source model: sends a burst of a requested number of pulses,
  HALF clocks high and HALF clocks low each. Shares the bench clock.
*/
module sysref_source #(parameter int HALF = 3) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] count_i,
  input wire logic go_i,
  output logic sysref_o,
  output logic idle_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] left_r;
  logic [7:0] phase_r;
  // Pulses of HALF >= 2 clocks, so the two-flop synchroniser sees each one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_r <= 12'h000;
      phase_r <= 8'h00;
    end else if (go_i && left_r == 12'h000) begin
      left_r <= count_i;
      phase_r <= 8'h00;
    end else if (left_r != 12'h000) begin
      if (phase_r == 8'(2 * HALF - 1)) begin
        phase_r <= 8'h00;
        left_r <= left_r - 12'h001;
      end else begin
        phase_r <= phase_r + 8'h01;
      end
    end
  end
  // Stands low between bursts, so no stray edge reaches the engine
  assign sysref_o = (left_r != 12'h000) && (phase_r < 8'(HALF));
  assign idle_o = (left_r == 12'h000);
endmodule : sysref_source
